/* File: hdl/ufc_pkg.sv */
// Constants, register map and level decoding for the FIFO control block
package ufc_pkg;
  // Register byte addresses
  localparam logic [7:0] UFC_IRQ_ENABLE_OFS  = 8'h04;
  localparam logic [7:0] UFC_FIFO_CONTROL_OFS = 8'h08;
  localparam logic [7:0] UFC_STATUS_OFS      = 8'h1c;
  // Reset values
  localparam logic [31:0] UFC_FIFO_CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] UFC_IRQ_ENABLE_RST   = 32'h0000_0000;
  // fifo_control field positions
  localparam int UFC_RTS_LVL_LSB = 16;
  localparam int UFC_RTS_LVL_MSB = 19;
  localparam int UFC_RX_OFF_BIT  = 8;
  localparam int UFC_RX_LVL_LSB  = 4;
  localparam int UFC_RX_LVL_MSB  = 7;
  localparam int UFC_TX_FLUSH_BIT = 2;
  localparam int UFC_RX_FLUSH_BIT = 1;
  // irq_enable and status field positions
  localparam int UFC_RX_LVL_IEN_BIT = 0;
  localparam int UFC_AUTO_RTS_BIT   = 12;
  localparam int UFC_FLAG_BIT       = 0;
  localparam int UFC_RTS_STATE_BIT  = 1;
  // Flush duration in engine clock cycles
  localparam int UFC_FLUSH_CYCLES = 3;
  localparam int UFC_CNT_W        = 7;
  // Byte levels selected by the four-bit level codes
  localparam logic [6:0] UFC_LVL_1  = 7'h01;
  localparam logic [6:0] UFC_LVL_4  = 7'h04;
  localparam logic [6:0] UFC_LVL_8  = 7'h08;
  localparam logic [6:0] UFC_LVL_14 = 7'h0e;
  localparam logic [6:0] UFC_LVL_30 = 7'h1e;
  localparam logic [6:0] UFC_LVL_46 = 7'h2e;
  localparam logic [6:0] UFC_LVL_62 = 7'h3e;

  // Map a level code to a byte count; normal channels cap at 14
  function automatic logic [6:0] ufc_level(input logic [3:0] code, input logic high_speed);
    logic [6:0] lvl;
    lvl = UFC_LVL_62;
    case (code)
      4'h0: lvl = UFC_LVL_1;
      4'h1: lvl = UFC_LVL_4;
      4'h2: lvl = UFC_LVL_8;
      4'h3: lvl = UFC_LVL_14;
      4'h4: lvl = high_speed ? UFC_LVL_30 : UFC_LVL_14;
      4'h5: lvl = high_speed ? UFC_LVL_46 : UFC_LVL_14;
      default: lvl = high_speed ? UFC_LVL_62 : UFC_LVL_14;
    endcase
    return lvl;
  endfunction
endpackage

/* File: hdl/ufc_flush_if.sv */
// Handshake between the control register and one flush sequencer
`timescale 1ns/1ps
interface ufc_flush_if;
  logic start;
  logic busy;
  modport ctrl (output start, input busy);
  modport seq  (input start, output busy);
endinterface

/* File: hdl/ufc_flush_seq.sv */
// Flush sequencer: holds a flush active for the fixed cycle count
`timescale 1ns/1ps
module ufc_flush_seq
  import ufc_pkg::*;
(
  // Clock and reset
  input wire logic  mclk,
  input wire logic  nrst,
  // Control side
  ufc_flush_if.seq  fl
);
  logic [1:0] cnt;
  wire        last = (cnt == 2'(UFC_FLUSH_CYCLES - 1));

  // Start (or restart) loads the counter; busy drops after the last cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fl.busy <= 1'b0;
      cnt     <= 2'h0;
    end else if (fl.start) begin
      fl.busy <= 1'b1;
      cnt     <= 2'h0;
    end else if (fl.busy) begin
      fl.busy <= !last;
      cnt     <= last ? 2'h0 : cnt + 2'h1;
    end
  end

  a_flush_min_len: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(fl.busy) |-> fl.busy [*3])
    else $error("flush shorter than three cycles");
endmodule // ufc_flush_seq

/* File: hdl/ufc_fifo_ctrl.sv */
// FIFO control word, trigger levels, auto RTS and flush control of one channel
`timescale 1ns/1ps
// Behaviour
// - fifo_control word sits at byte offset 0x08 and resets to zero.
// - RTS level code maps to 1,4,8,14 then 30,46,62 or 14 bytes.
// - Channel without auto flow control has no RTS level field.
// - Bit 8 set disables the receiver, cleared enables it.
// - Receive level field in bits 7:4 uses the same byte mapping.
// - Count equal to receive level sets flag; interrupt only when enabled.
// - Writing 1 to bit 2 flushes transmit FIFO and state; 0 does nothing.
// - Writing 1 to bit 1 flushes receive FIFO and state; 0 does nothing.
// - Flush bits self-clear after at least three engine clock cycles.
// - Auto RTS drops RTS when receive count equals RTS level.
// - Receive level interrupt enable is bit 0 of interrupt enable register.
module ufc_fifo_ctrl
  import ufc_pkg::*;
#(
  parameter bit HIGH_SPEED   = 1'b1,
  parameter bit HAS_AUTOFLOW = 1'b1
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  // Register port
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [31:0]          rdata,
  // FIFO side
  input  wire logic [UFC_CNT_W-1:0] rx_count,
  output logic                      tx_path_flush,
  output logic                      rx_path_flush,
  output logic                      receiver_off,
  // Flow control and receive event
  output logic                      rts,
  output logic                      rx_level_flag,
  output logic                      rx_level_interrupt
);
  import ufc_pkg::*;

  logic [3:0] rts_deassert_level;
  logic [3:0] rx_irq_level;
  logic       rx_level_irq_enable;
  logic       auto_rts;
  ufc_flush_if tx_fl ();
  ufc_flush_if rx_fl ();

  // Address decode
  wire sel_fc   = (addr == UFC_FIFO_CONTROL_OFS);
  wire sel_ie   = (addr == UFC_IRQ_ENABLE_OFS);
  wire sel_st   = (addr == UFC_STATUS_OFS);
  wire wr_fc    = wr && sel_fc;
  wire wr_ie    = wr && sel_ie;
  wire wr_st    = wr && sel_st;

  // Flush starts only on a written 1
  assign tx_fl.start = wr_fc && wdata[UFC_TX_FLUSH_BIT];
  assign rx_fl.start = wr_fc && wdata[UFC_RX_FLUSH_BIT];

  // Decoded byte levels
  wire [6:0] rx_lvl_bytes  = ufc_level(rx_irq_level, HIGH_SPEED);
  wire [6:0] rts_lvl_bytes = ufc_level(rts_deassert_level, HIGH_SPEED);
  wire       rx_hit        = (rx_count == rx_lvl_bytes);
  wire       rts_hit       = (rx_count >= rts_lvl_bytes);
  wire       auto_on       = HAS_AUTOFLOW && auto_rts;
  wire       next_rts      = !(auto_on && rts_hit);
  wire       next_flag     = rx_hit || (rx_level_flag && !(wr_st && wdata[UFC_FLAG_BIT]));

  // Readable images; reserved bits stay zero
  wire [31:0] fc_img = {12'h000, rts_deassert_level, 7'h00, receiver_off,
                        rx_irq_level, 1'b0, tx_fl.busy, rx_fl.busy, 1'b0};
  wire [31:0] ie_img = {19'h00000, auto_rts, 11'h000, rx_level_irq_enable};
  wire [31:0] st_img = {30'h0, rts, rx_level_flag};
  wire [31:0] next_rdata = !rd   ? 32'h0000_0000 :
                           sel_fc ? fc_img :
                           sel_ie ? ie_img :
                           sel_st ? st_img : 32'h0000_0000;

  // Flush sequencers, one per direction
  ufc_flush_seq u_tx_flush (.mclk(mclk), .nrst(nrst), .fl(tx_fl));
  ufc_flush_seq u_rx_flush (.mclk(mclk), .nrst(nrst), .fl(rx_fl));

  // fifo_control fields
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rts_deassert_level <= UFC_FIFO_CONTROL_RST[UFC_RTS_LVL_MSB:UFC_RTS_LVL_LSB];
      receiver_off       <= UFC_FIFO_CONTROL_RST[UFC_RX_OFF_BIT];
      rx_irq_level       <= UFC_FIFO_CONTROL_RST[UFC_RX_LVL_MSB:UFC_RX_LVL_LSB];
    end else if (wr_fc) begin
      rts_deassert_level <= HAS_AUTOFLOW ? wdata[UFC_RTS_LVL_MSB:UFC_RTS_LVL_LSB] : 4'h0;
      receiver_off       <= wdata[UFC_RX_OFF_BIT];
      rx_irq_level       <= wdata[UFC_RX_LVL_MSB:UFC_RX_LVL_LSB];
    end
  end

  // Interrupt enable register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_level_irq_enable <= UFC_IRQ_ENABLE_RST[UFC_RX_LVL_IEN_BIT];
      auto_rts            <= UFC_IRQ_ENABLE_RST[UFC_AUTO_RTS_BIT];
    end else if (wr_ie) begin
      rx_level_irq_enable <= wdata[UFC_RX_LVL_IEN_BIT];
      auto_rts            <= HAS_AUTOFLOW && wdata[UFC_AUTO_RTS_BIT];
    end
  end

  // Outputs, flag and read data
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata              <= 32'h0000_0000;
      rts                <= 1'b1;
      rx_level_flag      <= 1'b0;
      rx_level_interrupt <= 1'b0;
      tx_path_flush      <= 1'b0;
      rx_path_flush      <= 1'b0;
    end else begin
      rdata              <= next_rdata;
      rts                <= next_rts;
      rx_level_flag      <= next_flag;
      rx_level_interrupt <= next_flag && rx_level_irq_enable;
      tx_path_flush      <= tx_fl.start || tx_fl.busy;
      rx_path_flush      <= rx_fl.start || rx_fl.busy;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_flag_sets: assert property (rx_hit |=> rx_level_flag)
    else $error("level match did not set flag");
  a_irq_masked: assert property (!rx_level_irq_enable |=> !rx_level_interrupt)
    else $error("interrupt raised while masked");
  a_irq_follows: assert property (rx_level_irq_enable && rx_hit |=> rx_level_interrupt)
    else $error("enabled level match gave no interrupt");
  a_rts_drop: assert property (auto_on && rx_count == rts_lvl_bytes |=> !rts)
    else $error("RTS not dropped at level");
  a_rts_manual: assert property (!auto_on |=> rts)
    else $error("RTS dropped without auto flow");
  a_tx_flush_run: assert property (tx_fl.start |=> tx_path_flush [*3])
    else $error("transmit flush too short");
  a_rx_flush_run: assert property (rx_fl.start |=> rx_path_flush [*3])
    else $error("receive flush too short");
  a_flush_zero: assert property (wr_fc && !wdata[UFC_RX_FLUSH_BIT] && !rx_fl.busy
    |=> !rx_path_flush)
    else $error("writing zero started a flush");
  a_rx_off_bit: assert property (wr_fc |=> receiver_off == $past(wdata[UFC_RX_OFF_BIT]))
    else $error("receiver_off not stored");
  a_reserved_zero: assert property (rd && sel_fc |=> (rdata & 32'hfff0_fe09) == 32'h0)
    else $error("reserved bits read nonzero");
  a_no_rts_field: assert property (!HAS_AUTOFLOW |-> rts_deassert_level == 4'h0)
    else $error("RTS level present on channel without flow control");

  // Flag, interrupt, RTS, field and read-back behaviour between writes
  // Flag holds until software clears it
  a_flag_sticky: assert property (
    rx_level_flag && !(wr_st && wdata[UFC_FLAG_BIT]) |=> rx_level_flag)
    else $error("flag dropped without a clear");
  // A clear with no match in the same cycle empties the flag
  a_flag_clear: assert property (
    wr_st && wdata[UFC_FLAG_BIT] && !rx_hit |=> !rx_level_flag)
    else $error("flag survived a clear");
  // Only a level match sets the flag
  a_flag_no_cause: assert property (
    !rx_level_flag && !rx_hit |=> !rx_level_flag)
    else $error("flag set without a level match");
  // The interrupt never stands without the flag
  a_irq_needs_flag: assert property (
    rx_level_interrupt |-> rx_level_flag)
    else $error("interrupt without flag");
  // RTS returns once the count is below the level
  a_rts_release: assert property (
    auto_on && rx_count < rts_lvl_bytes |=> rts)
    else $error("RTS held low below level");
  // RTS stays low while the count is above the level
  a_rts_above: assert property (
    auto_on && rx_count > rts_lvl_bytes |=> !rts)
    else $error("RTS raised above level");
  // Receiver state changes only on a control word write
  a_rx_off_hold: assert property (
    !wr_fc |=> $stable(receiver_off))
    else $error("receiver_off changed without a write");
  // Receive level changes only on a control word write
  a_lvl_hold: assert property (
    !wr_fc |=> $stable(rx_irq_level))
    else $error("receive level changed without a write");
  // RTS level changes only on a control word write
  a_rts_lvl_hold: assert property (
    !wr_fc |=> $stable(rts_deassert_level))
    else $error("RTS level changed without a write");
  // Normal-speed channels never go above fourteen bytes
  a_normal_cap: assert property (
    !HIGH_SPEED |-> rx_lvl_bytes <= UFC_LVL_14 && rts_lvl_bytes <= UFC_LVL_14)
    else $error("normal-speed level above fourteen");
  // The four low codes stay within fourteen bytes on any channel
  a_low_codes: assert property (
    rx_irq_level < 4'h4 |-> rx_lvl_bytes <= UFC_LVL_14)
    else $error("low code decoded above fourteen");
  // A transmit flush ends by itself without a new start
  a_tx_self_clear: assert property (
    tx_fl.start ##1 !tx_fl.start [*5] |-> !tx_path_flush)
    else $error("transmit flush did not clear itself");
  // A receive flush ends by itself without a new start
  a_rx_self_clear: assert property (
    rx_fl.start ##1 !rx_fl.start [*5] |-> !rx_path_flush)
    else $error("receive flush did not clear itself");
  // Writing zero to the transmit flush bit starts nothing
  a_tx_flush_zero: assert property (
    wr_fc && !wdata[UFC_TX_FLUSH_BIT] && !tx_fl.busy |=> !tx_path_flush)
    else $error("writing zero started a transmit flush");
  // Read data stand only in the cycle after a read
  a_rdata_idle: assert property (
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data outside a read cycle");
  // Unmapped addresses read as zero
  a_unmapped_zero: assert property (
    rd && !sel_fc && !sel_ie && !sel_st |=> rdata == 32'h0000_0000)
    else $error("unmapped address read nonzero");
  // Interrupt enable word shows only its two defined bits
  a_ie_reserved: assert property (
    rd && sel_ie |=> (rdata & 32'hffff_effe) == 32'h0000_0000)
    else $error("interrupt enable reserved bits nonzero");
  // Auto RTS cannot be enabled without flow control
  a_no_auto: assert property (
    !HAS_AUTOFLOW |-> !auto_rts)
    else $error("auto RTS enabled on channel without flow control");
endmodule // ufc_fifo_ctrl

/* File: tb/ufc_peer_model.sv */
// Far-side serial device streaming bytes into the receive FIFO
`timescale 1ns/1ps
module ufc_peer_model
  import ufc_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  // Link side
  input  wire logic                 send,
  input  wire logic                 rts,
  input  wire logic                 rx_path_flush,
  output logic      [UFC_CNT_W-1:0] rx_count
);
  // One byte per cycle while RTS allows it; a flush empties the FIFO
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      rx_count <= '0;
    else if (rx_path_flush)
      rx_count <= '0;
    else if (send && rts && rx_count < 7'h7f)
      rx_count <= rx_count + 7'h01;
  end
endmodule // ufc_peer_model

/* File: tb/testbench.sv */
// Self-checking bench for the FIFO control block
`timescale 1ns/1ps
module testbench;
  import ufc_pkg::*;
  logic                 mclk = 1'b0;
  logic                 nrst = 1'b0;
  logic [7:0]           addr = 8'h00;
  logic [31:0]          wdata = 32'h0;
  logic                 wr = 1'b0;
  logic                 rd = 1'b0;
  logic                 send = 1'b0;
  logic [31:0]          rdata;
  logic [31:0]          seed;
  logic [3:0]           code;
  logic [UFC_CNT_W-1:0] rx_count;
  logic                 tx_path_flush, rx_path_flush, receiver_off;
  logic                 rts, rx_level_flag, rx_level_interrupt;
  logic [31:0]          slow_rdata;
  logic                 slow_rts, slow_flag;
  int                   num_errors = 0;
  int                   checks = 0;
  int                   n, nt, nr, lvl, slow_at;
  int                   lvl_tab[7] = '{1, 4, 8, 14, 30, 46, 62};

  // Clock
  always #12.5 mclk = ~mclk;

  ufc_fifo_ctrl dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx_count(rx_count), .tx_path_flush(tx_path_flush),
    .rx_path_flush(rx_path_flush), .receiver_off(receiver_off), .rts(rts),
    .rx_level_flag(rx_level_flag), .rx_level_interrupt(rx_level_interrupt));
  ufc_peer_model peer (.mclk(mclk), .nrst(nrst), .send(send), .rts(rts),
    .rx_path_flush(rx_path_flush), .rx_count(rx_count));
  // Normal-speed channel without auto flow control on the same bus
  ufc_fifo_ctrl #(.HIGH_SPEED(1'b0), .HAS_AUTOFLOW(1'b0)) dut_slow (.mclk(mclk),
    .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(slow_rdata),
    .rx_count(rx_count), .tx_path_flush(), .rx_path_flush(), .receiver_off(),
    .rts(slow_rts), .rx_level_flag(slow_flag), .rx_level_interrupt());

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(what, rdata, exp);
  endtask

  // Count the cycles each flush output stays high after a write
  task automatic flush_len(input logic [31:0] d);
    nt = 0;
    nr = 0;
    bus_wr(UFC_FIFO_CONTROL_OFS, d);
    repeat (8) begin
      @(negedge mclk);
      nt += int'(tx_path_flush === 1'b1);
      nr += int'(rx_path_flush === 1'b1);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 32'h4abb319d;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    bus_rd(UFC_FIFO_CONTROL_OFS, 32'h0, "fifo_control reset");
    bus_rd(UFC_IRQ_ENABLE_OFS, 32'h0, "irq_enable reset");
    bus_rd(8'h0c, 32'h0, "unmapped read");
    bus_wr(UFC_FIFO_CONTROL_OFS, 32'hffff_ffff);
    repeat (6) @(posedge mclk);
    bus_rd(UFC_FIFO_CONTROL_OFS, 32'h000f_01f0, "fifo_control image");
    chk("fifo_control no flow control", slow_rdata, 32'h0000_01f0);
    chk("receiver_off", receiver_off, 1'b1);
    flush_len(32'h0000_0006);
    chk("tx flush long enough", nt >= 3, 1'b1);
    chk("rx flush long enough", nr >= 3, 1'b1);
    flush_len(32'h0000_0000);
    chk("tx flush on zero", nt, 32'h0);
    chk("rx flush on zero", nr, 32'h0);
    // Flush bits read back as one while their flush runs
    bus_wr(UFC_FIFO_CONTROL_OFS, 32'h0000_0006);
    bus_rd(UFC_FIFO_CONTROL_OFS, 32'h0000_0006, "flush bits while busy");
    // Level codes 0 to 6 and one random code from 8 to 15, with random interrupt enable and receiver state
    for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      code = (c == 7) ? {1'b1, seed[4:2]} : 4'(c);
      lvl = lvl_tab[(code > 4'h6) ? 6 : int'(code)];
      bus_wr(UFC_IRQ_ENABLE_OFS, {19'h0, 1'b1, 11'h0, seed[0]});
      // Receiver state is settled here, with both level codes and a receive flush
      bus_wr(UFC_FIFO_CONTROL_OFS, {12'h0, code, 7'h0, seed[1], code, 4'h2});
      repeat (5) @(negedge mclk);
      chk("receiver_off", receiver_off, seed[1]);
      chk("rts after flush", rts, 1'b1);
      bus_wr(UFC_STATUS_OFS, 32'h1);
      bus_rd(UFC_STATUS_OFS, 32'h2, "status cleared");
      @(posedge mclk);
      send <= 1'b1;
      n = 0;
      slow_at = 0;
      while (rts !== 1'b0 && n < 100) begin
        @(negedge mclk);
        n++;
        if (slow_flag === 1'b1 && slow_at == 0)
          slow_at = int'(rx_count);
      end
      if (n == 100) begin
        num_errors++;
        complete_run();
      end
      chk("rx_count at rts drop", rx_count, lvl + 1);
      chk("rx_level_flag", rx_level_flag, 1'b1);
      chk("normal-speed flag count", slow_at, ((lvl > 14) ? 14 : lvl) + 1);
      chk("rts without flow control", slow_rts, 1'b1);
      @(posedge mclk);
      send <= 1'b0;
      @(negedge mclk);
      chk("rx_level_interrupt", rx_level_interrupt, seed[0]);
      bus_rd(UFC_STATUS_OFS, 32'h1, "status flag set");
    end
    complete_run();
  end
endmodule // testbench
